// [core/hsrt_pkg.sv]
/*
 * Package for the high-side recopy trim register block: register
 * offset, field positions, reset value and trim code encodings.
 * Assumes an 8-bit internal register port with a 6-bit address.
 */
// Functional notes
// - Register at 0x11, every bit reads zero
// - Bits 7:6 half-bridge trim, reset clears
// - Two-bit code: 0, -10%, +5%, +10%
// - Bits 5:3 switch two/three trim, reset clears
// - Three-bit code: 0,-5,-10,-15,res,+5,+10,+15
// - Bits 2:0 switch one trim, reset clears
package hsrt_pkg;
   localparam int          HSRT_ADDR_W      = 6;
   localparam int          HSRT_DATA_W      = 8;
   localparam logic [5:0]  HSRT_TRIM_OFFSET = 6'h11;
   localparam logic [7:0]  HSRT_TRIM_RESET  = 8'h00;
   localparam logic [7:0]  HSRT_READ_VALUE  = 8'h00;
   localparam int          HSRT_BRIDGE_MSB  = 7;
   localparam int          HSRT_BRIDGE_LSB  = 6;
   localparam int          HSRT_SW23_MSB    = 5;
   localparam int          HSRT_SW23_LSB    = 3;
   localparam int          HSRT_SW1_MSB     = 2;
   localparam int          HSRT_SW1_LSB     = 0;
   localparam logic [15:0] HSRT_FLASH_ADDR  = 16'hFDC6;

   // Half-bridge recopy adjustment codes
   typedef enum logic [1:0]
   {
      HSRT_BR_NONE   = 2'h0,
      HSRT_BR_MINUS10 = 2'h1,
      HSRT_BR_PLUS5  = 2'h2,
      HSRT_BR_PLUS10 = 2'h3
   } hsrt_bridge_code_t;

   // High-side recopy adjustment codes
   typedef enum logic [2:0]
   {
      HSRT_SW_NONE    = 3'h0,
      HSRT_SW_MINUS5  = 3'h1,
      HSRT_SW_MINUS10 = 3'h2,
      HSRT_SW_MINUS15 = 3'h3,
      HSRT_SW_RESVD   = 3'h4,
      HSRT_SW_PLUS5   = 3'h5,
      HSRT_SW_PLUS10  = 3'h6,
      HSRT_SW_PLUS15  = 3'h7
   } hsrt_switch_code_t;
endpackage : hsrt_pkg

// [core/hsrt_trim_reg.sv]
/*
 * Write-only recopy trim register of the analog die. Holds the
 * half-bridge three/four trim and both high-side trims, and decodes
 * them into signed percent steps for the analog recopy stages.
 *
 * Assumes the serial link slave delivers one-cycle write and read
 * strobes with address and data on the same clock. All inputs come
 * from logic in the clk_sys_in domain, so none is synchronised here.
 * The processor side must reload the factory byte after each reset.
 */
`timescale 1ns/1ps

module hsrt_trim_reg
#(
   parameter int ADDR_W = hsrt_pkg::HSRT_ADDR_W,  // Address width
   parameter int DATA_W = hsrt_pkg::HSRT_DATA_W   // Data width
)
(
   input  wire logic                clk_sys_in,    // System clock
   input  wire logic                reset_in,      // Sync reset, high
   input  wire logic                clk_en_in,     // Freezes state low
   input  wire logic [ADDR_W-1:0]   addr_in,       // Register address
   input  wire logic                wr_en_in,      // Write strobe
   input  wire logic [DATA_W-1:0]   wr_data_in,    // Write data
   input  wire logic                rd_en_in,      // Read strobe
   output logic      [DATA_W-1:0]   rd_data_out,   // Read data
   output logic      [1:0]          upper_bridge_trim_low_range_out, // Bridge
   output logic      [2:0]          second_third_switch_trim_out, // Sw 2/3
   output logic      [2:0]          first_switch_trim_out,         // Sw 1
   output logic signed [4:0]        bridge_adjust_pct_out, // Bridge percent
   output logic signed [4:0]        sw23_adjust_pct_out,   // Sw 2/3 percent
   output logic signed [4:0]        sw1_adjust_pct_out,    // Sw 1 percent
   output logic                     reserved_code_out      // Code 100 held
);
   import hsrt_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Elaboration check
   // The field layout is fixed to one byte; the address must be at least six bits
   generate
      if ((DATA_W != 8) || (ADDR_W < 6))
      begin : g_bad_params
         $error("hsrt_trim_reg: DATA_W must be 8, ADDR_W at least 6");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Declarations

   // Register state
   logic [DATA_W-1:0]      trim;             // Written trim byte
   logic [DATA_W-1:0]      next_trim;        // Trim after this edge
   logic [DATA_W-1:0]      next_rd_data;     // Read data after edge
   logic                   wr_hit;           // Write to our offset

   // Bridge decode state
   logic signed [4:0]      next_bridge_pct;  // Bridge percent next
   logic                   next_reserved;    // Reserved flag next

   // Per-switch decode results, index 0 is switch one
   logic signed [4:0]      sw_pct_q [2];     // Registered percent

   ////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Three-bit high-side code to signed percent
   function automatic logic signed [4:0] sw_pct(input logic [2:0] code);
      case (hsrt_switch_code_t'(code))
         HSRT_SW_MINUS5:  sw_pct = -5'sd5;
         HSRT_SW_MINUS10: sw_pct = -5'sd10;
         HSRT_SW_MINUS15: sw_pct = -5'sd15;
         HSRT_SW_PLUS5:   sw_pct = 5'sd5;
         HSRT_SW_PLUS10:  sw_pct = 5'sd10;
         HSRT_SW_PLUS15:  sw_pct = 5'sd15;
         // Reserved code maps to no adjustment, flagged apart
         default:         sw_pct = 5'sd0;
      endcase
   endfunction : sw_pct

   ////////////////////////////////////////////////////////////////////
   // Register group

   // Address match; other offsets belong to other blocks
   assign wr_hit = wr_en_in && (addr_in == ADDR_W'(HSRT_TRIM_OFFSET));

   // Next trim byte and read data
   always_comb
   begin
      next_trim    = trim;
      next_rd_data = rd_data_out;
      if (wr_hit)
      begin
         // Whole byte at once, no partial field writes
         next_trim = wr_data_in;
      end
      if (rd_en_in)
      begin
         // Write-only fields never leak onto the read path
         next_rd_data = HSRT_READ_VALUE;
      end
   end

   // Trim byte and read data flip-flops
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         trim        <= HSRT_TRIM_RESET;
         rd_data_out <= HSRT_READ_VALUE;
      end
      else if (clk_en_in)
      begin
         trim        <= next_trim;
         rd_data_out <= next_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Bridge decode group

   // Bridge percent and reserved flag from the held byte
   always_comb
   begin
      case (hsrt_bridge_code_t'(trim[HSRT_BRIDGE_MSB:HSRT_BRIDGE_LSB]))
         HSRT_BR_MINUS10: next_bridge_pct = -5'sd10;
         HSRT_BR_PLUS5:   next_bridge_pct = 5'sd5;
         HSRT_BR_PLUS10:  next_bridge_pct = 5'sd10;
         default:         next_bridge_pct = 5'sd0;
      endcase
      // Flags the undefined code so software misuse is visible
      next_reserved =
         (trim[HSRT_SW23_MSB:HSRT_SW23_LSB] == HSRT_SW_RESVD) ||
         (trim[HSRT_SW1_MSB:HSRT_SW1_LSB] == HSRT_SW_RESVD);
   end

   // Bridge percent and reserved flag flip-flops
   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         bridge_adjust_pct_out <= 5'sd0;
         reserved_code_out     <= 1'b0;
      end
      else if (clk_en_in)
      begin
         bridge_adjust_pct_out <= next_bridge_pct;
         reserved_code_out     <= next_reserved;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Switch decode group, one pass per three-bit field

   // Both switch fields share one code table and one timing
   for (genvar g = 0; g < 2; g++)
   begin : g_sw
      localparam int LSB = (g == 0) ? HSRT_SW1_LSB : HSRT_SW23_LSB;

      logic [2:0]        field;     // Field slice of the trim byte
      logic signed [4:0] next_pct;  // Percent after this edge

      // Decode of this field
      always_comb
      begin
         field    = trim[LSB +: 3];
         next_pct = sw_pct(field);
      end

      // Registered percent of this field
      always_ff @(posedge clk_sys_in)
      begin
         if (reset_in)
         begin
            sw_pct_q[g] <= 5'sd0;
         end
         else if (clk_en_in)
         begin
            sw_pct_q[g] <= next_pct;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   // Percent outputs straight from the per-field flip-flops
   assign sw1_adjust_pct_out  = sw_pct_q[0];
   assign sw23_adjust_pct_out = sw_pct_q[1];

   // Raw fields straight from the trim flip-flops
   assign upper_bridge_trim_low_range_out =
      trim[HSRT_BRIDGE_MSB:HSRT_BRIDGE_LSB];
   assign second_third_switch_trim_out = trim[HSRT_SW23_MSB:HSRT_SW23_LSB];
   assign first_switch_trim_out        = trim[HSRT_SW1_MSB:HSRT_SW1_LSB];
endmodule : hsrt_trim_reg

// [sim/hsrt_flash_model.sv]
/* Factory trim store seen by the processor side.
   Assumes the bench copies its byte into the trim register. */
`timescale 1ns/1ps
module hsrt_flash_model #(parameter logic [15:0] LOC = 16'hFDC6)
   (output logic [7:0] trim_out); // Stored trim byte
   // Byte at LOC, value arbitrary
   assign trim_out = 8'hEF;
endmodule : hsrt_flash_model

// [sim/hsrt_chk_assertions.sv]
/* Port checker for the trim register.
   Assumes binding onto hsrt_trim_reg. */
`timescale 1ns/1ps
module hsrt_chk import hsrt_pkg::*; (
   input wire logic clk_sys_in, reset_in, clk_en_in, wr_en_in, rd_en_in,
   input wire logic [5:0] addr_in, input wire logic [7:0] wr_data_in,
   input wire logic [7:0] rd_data_out, input wire logic rsv,
   input wire logic [1:0] br, input wire logic [2:0] s23, s1,
   input wire logic signed [4:0] pb, p23, p1);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   wire wr = clk_en_in && wr_en_in && addr_in == HSRT_TRIM_OFFSET;
   AST_RD: assert property (rd_data_out == 8'h00) else $error("rd");
   AST_BR: assert property (wr |=> br == $past(wr_data_in[7:6]))
      else $error("br");
   AST_S23: assert property (wr |=> s23 == $past(wr_data_in[5:3]))
      else $error("s23");
   AST_S1: assert property (wr |=> s1 == $past(wr_data_in[2:0]))
      else $error("s1");
   AST_HOLD: assert property (!wr && !reset_in |=> $stable({br, s23, s1}))
      else $error("hold");
   AST_PB: assert property (clk_en_in && br == 2'h1 |=> pb == 5'h16)
      else $error("pb");
   AST_P23: assert property (clk_en_in && s23 == 3'h3 |=> p23 == 5'h11)
      else $error("p23");
   AST_P1: assert property (clk_en_in && s1 == 3'h7 |=> p1 == 5'h0F)
      else $error("p1");
   AST_RSV: assert property (clk_en_in && s23 == 3'h4 |=> rsv)
      else $error("rsv");
endmodule : hsrt_chk
bind hsrt_trim_reg hsrt_chk i_chk(.clk_sys_in, .reset_in, .clk_en_in,
   .wr_en_in, .rd_en_in, .addr_in, .wr_data_in, .rd_data_out,
   .rsv(reserved_code_out), .br(upper_bridge_trim_low_range_out),
   .s23(second_third_switch_trim_out), .s1(first_switch_trim_out),
   .pb(bridge_adjust_pct_out), .p23(sw23_adjust_pct_out),
   .p1(sw1_adjust_pct_out));

// [sim/tb_top.sv]
/* Testbench for the trim register.
   Assumes the design package and flash model are compiled first. */
`timescale 1ns/1ps
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
$display("Error %0t: value mismatch", $time); end end
module tb_top;
   import hsrt_pkg::*;
   logic clk_sys_in = 0, reset_in = 1, clk_en_in = 1, wr_en_in = 0;
   logic rd_en_in = 0, rsv;
   logic [5:0] addr_in = '0;
   logic [7:0] wr_data_in = '0, rd_data_out, fl;
   logic [1:0] br;
   logic [2:0] s23, s1;
   logic signed [4:0] pb, p23, p1;
   logic signed [4:0] e3 [8] = '{5'h00, 5'h1B, 5'h16, 5'h11,
                                 5'h00, 5'h05, 5'h0A, 5'h0F};
   logic signed [4:0] e2 [4] = '{5'h00, 5'h16, 5'h05, 5'h0A};
   int n_fail = 0, n_tests = 0;
   hsrt_trim_reg i_dut(.clk_sys_in, .reset_in, .clk_en_in, .addr_in,
      .wr_en_in, .wr_data_in, .rd_en_in, .rd_data_out,
      .upper_bridge_trim_low_range_out(br), .second_third_switch_trim_out(s23),
      .first_switch_trim_out(s1), .bridge_adjust_pct_out(pb),
      .sw23_adjust_pct_out(p23), .sw1_adjust_pct_out(p1),
      .reserved_code_out(rsv));
   hsrt_flash_model i_fl(.trim_out(fl));
   // Clock and watchdog
   initial forever #5 clk_sys_in = ~clk_sys_in;
   initial begin #100us; n_fail++; test_done; end
   // One write cycle, then wait for the decoded outputs
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys_in) {addr_in, wr_data_in, wr_en_in} <= {a, d, 1'b1};
      @(posedge clk_sys_in) wr_en_in <= 1'b0;
      @(posedge clk_sys_in) #1;
   endtask : wr
   // Fields, percent decode and reserved flag
   task chk(input logic [7:0] d);
      `CHK({br, s23, s1}, d)
      `CHK(pb, e2[d[7:6]])
      `CHK(p23, e3[d[5:3]])
      `CHK(p1, e3[d[2:0]])
      `CHK(rsv, d[5:3] == 3'h4 || d[2:0] == 3'h4)
   endtask : chk
   task test_done;
      $display("fails %0d checks %0d", n_fail, n_tests);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      @(posedge clk_sys_in) #1;
      chk(8'h00);
      wr(HSRT_TRIM_OFFSET, fl); chk(fl);
      for (int i = 0; i < 8; i++) begin
         wr(HSRT_TRIM_OFFSET, {i[1:0], i[2:0], 3'(7 - i)});
         chk({i[1:0], i[2:0], 3'(7 - i)});
      end
      wr(6'h10, 8'h00); chk(8'hF8);
      @(posedge clk_sys_in) clk_en_in <= 1'b0;
      wr(HSRT_TRIM_OFFSET, 8'h00); chk(8'hF8);
      @(posedge clk_sys_in) clk_en_in <= 1'b1;
      @(posedge clk_sys_in) {addr_in, rd_en_in} <= {HSRT_TRIM_OFFSET, 1'b1};
      @(posedge clk_sys_in) rd_en_in <= 1'b0;
      @(posedge clk_sys_in) #1 `CHK(rd_data_out, 8'h00)
      @(posedge clk_sys_in) reset_in <= 1'b1;
      @(posedge clk_sys_in) reset_in <= 1'b0;
      @(posedge clk_sys_in) #1 chk(8'h00);
      test_done;
   end
endmodule : tb_top
